// ==== xrsa_pkg.sv ====
`default_nettype none
package xrsa_pkg;
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFS_GEN = 8'h00;
	localparam logic [7:0] OFS_SEG = 8'h40;
	localparam logic [7:0] OFS_IP = 8'h50;
	localparam logic [7:0] OFS_FLAGS = 8'h54;
	localparam logic [7:0] OFS_OPND = 8'h58;
	localparam logic [7:0] OFS_ALU = 8'h5C;
	localparam logic [7:0] OFS_AGEN = 8'h60;
	localparam logic [7:0] OFS_PHYS = 8'h64;
	localparam logic [7:0] OFS_PORT = 8'h68;
	localparam logic [7:0] OFS_STEP = 8'h6C;
	localparam logic [7:0] OFS_SAVED = 8'h70;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CF_BIT = 0;
	localparam int PF_BIT = 2;
	localparam int AF_BIT = 4;
	localparam int ZF_BIT = 6;
	localparam int SF_BIT = 7;
	localparam int TF_BIT = 8;
	localparam int IF_BIT = 9;
	localparam int DF_BIT = 10;
	localparam int OF_BIT = 11;
	localparam logic [15:0] FLAG_MASK = 16'h0FD5;
	localparam logic [15:0] FLAG_RSV = 16'hF002;
	localparam logic [2:0] IDX_ACC = 3'h0;
	localparam logic [2:0] IDX_COUNT = 3'h1;
	localparam logic [2:0] IDX_DATA = 3'h2;
	localparam logic [2:0] IDX_BASE = 3'h3;
	localparam logic [2:0] IDX_SP = 3'h4;
	localparam logic [2:0] IDX_BP = 3'h5;
	localparam logic [2:0] IDX_SI = 3'h6;
	localparam logic [2:0] IDX_DI = 3'h7;
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_CODE = 2'h1;
	localparam logic [1:0] SEG_STACK = 2'h2;
	localparam logic [1:0] SEG_DATA = 2'h3;
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] RSV_PORT_LO = 16'h00F8;
	localparam logic [15:0] RSV_PORT_HI = 16'h00FF;
	typedef enum logic [1:0] {
		OP_ADD = 2'b00,
		OP_SUB = 2'b01,
		OP_AND = 2'b10,
		OP_OR = 2'b11
	} xrsa_op_type;
endpackage
`default_nettype wire

// ==== xrsa_pkg_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== xrsa_register_set.sv ====
// What this block does
// - Eight 16-bit general registers; four split into independent byte halves.
// - Base pointer, base word and index registers may supply offset bases.
// - Stack accesses use stack pointer offset in stack segment, never overridden.
// - Four 16-bit segment registers for code, data, extra and stack.
// - A 16-bit instruction pointer holds the next instruction offset.
// - Peripheral registers are not part of this register set.
// - Each flag is set, cleared, kept or undefined after an instruction.
// - Status flags in bits 0,2,4,6,7,11; control flags in 8,9,10.
// - Overflow flag set when signed result does not fit the width.
// - Direction flag set decrements string indexes, clear increments them.
// - Maskable interrupts are taken only while interrupt-enable is set.
// - Trace flag raises a trace interrupt; cleared after flags are pushed.
// - Sign flag takes the result's most significant bit.
// - Zero flag set when the result is zero.
// - Half carry flag marks carry or borrow across low accumulator nibble.
// - Parity flag set when low result byte has even ones.
// - Carry flag marks carry out of or borrow into result msb.
// - Physical address is segment shifted left four plus offset.
// - Each segment spans 64K bytes addressed by a 16-bit offset.
// - Separate I/O space of 64K byte or 32K word ports.
// - Port number is 8-bit immediate zero-extended or 16-bit data word.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module xrsa_register_set
	import xrsa_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irqIn,
	output logic intAck,
	output logic traceIrq,
	output logic [19:0] memAddr,
	output logic [15:0] ioAddr,
	output logic ioAddrReserved
);
	logic [15:0] gen_reg [0:7];
	logic [15:0] seg_reg [0:3];
	logic [15:0] ip_reg;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [15:0] opnd_reg;
	logic [15:0] result_reg;
	logic [15:0] saved_reg;
	logic [AXI_AW-1:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;
	logic [7:0] wa;
	logic [31:0] wd;
	logic wrGen, wrSeg, wrIp, wrFlags, wrOpnd, wrAlu;
	logic wrAgen, wrPort, wrStep;
	logic stepEnd, takeIrq, takeTrace, doRet, strStep;
	logic [15:0] strDelta;
	logic [16:0] sum;
	logic [15:0] aluA, aluB, aluRes;
	xrsa_op_type aluOp;
	logic byteMode, arith, msbA, msbB, msbR, cOut, ovf, half;
	logic [15:0] agenOfs, agenBase;
	logic [15:0] agenSeg;
	logic [31:0] rdWord;
	logic rdHit;

	// Byte strobes give each half of a word its own write path.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// Carry out of bit 19 is simply not kept.
	function automatic logic [19:0] physAddr(input logic [15:0] seg,
		input logic [15:0] ofs);
		return {seg, 4'h0} + {4'h0, ofs};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && (a < 8'h20 || a >= OFS_SEG)
			&& a <= OFS_SAVED;
	endfunction

	assign wa = awAddr_reg[7:0];
	assign wd = wData_reg;
	assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wrGen = doWrite && wa[7:5] == 3'b000 && wa[1:0] == 2'b00;
	assign wrSeg = doWrite && wa[7:4] == OFS_SEG[7:4] && wa[1:0] == 2'b00;
	assign wrIp = doWrite && wa == OFS_IP;
	assign wrFlags = doWrite && wa == OFS_FLAGS;
	assign wrOpnd = doWrite && wa == OFS_OPND;
	assign wrAlu = doWrite && wa == OFS_ALU;
	assign wrAgen = doWrite && wa == OFS_AGEN;
	assign wrPort = doWrite && wa == OFS_PORT;
	assign wrStep = doWrite && wa == OFS_STEP;
	assign stepEnd = wrStep && wd[0];
	assign takeIrq = stepEnd && irqIn && flags_reg[IF_BIT];
	assign takeTrace = stepEnd && !takeIrq && flags_reg[TF_BIT];
	assign doRet = wrStep && wd[1] && !takeIrq && !takeTrace;
	assign strStep = wrStep && wd[2];
	assign strDelta = wd[3] ? 16'h0002 : 16'h0001;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			awAddr_reg <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awAddr_reg <= s_axi_awaddr;
		end else if (doWrite) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_wready <= 1'b1;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
		end else if (doWrite) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Peripheral registers live elsewhere; holes answer with an error.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		aluA = gen_reg[IDX_ACC];
		aluB = opnd_reg;
		aluOp = xrsa_op_type'(wd[1:0]);
		byteMode = wd[2];
		case (aluOp)
			OP_ADD: sum = {1'b0, aluA} + {1'b0, aluB};
			OP_SUB: sum = {1'b0, aluA} - {1'b0, aluB};
			OP_AND: sum = {1'b0, aluA & aluB};
			default: sum = {1'b0, aluA | aluB};
		endcase
		aluRes = byteMode ? {8'h00, sum[7:0]} : sum[15:0];
		msbA = byteMode ? aluA[7] : aluA[15];
		msbB = byteMode ? aluB[7] : aluB[15];
		msbR = byteMode ? aluRes[7] : aluRes[15];
		arith = aluOp == OP_ADD || aluOp == OP_SUB;
		// The bit-8 carry is rebuilt from the operands in byte mode.
		cOut = arith && (byteMode ? aluA[8] ^ aluB[8] ^ sum[8]
			: sum[16]);
		ovf = arith && (msbR != msbA) && ((aluOp == OP_ADD) ?
			(msbA == msbB) : (msbA != msbB));
		half = aluA[4] ^ aluB[4] ^ sum[4];
	end

	always_comb begin
		flags_next = flags_reg;
		if (wrFlags) begin
			flags_next = merge16(flags_reg, wd[15:0], wStrb_reg[1:0]);
		end else if (wrAlu) begin
			flags_next[CF_BIT] = cOut;
			flags_next[OF_BIT] = ovf;
			flags_next[SF_BIT] = msbR;
			flags_next[ZF_BIT] = aluRes == 16'h0000;
			flags_next[PF_BIT] = ~^aluRes[7:0];
			// Logic ops leave the half carry alone, which is undefined.
			if (arith) begin
				flags_next[AF_BIT] = half;
			end
		end else if (takeIrq) begin
			flags_next[IF_BIT] = 1'b0;
			flags_next[TF_BIT] = 1'b0;
		end else if (takeTrace) begin
			flags_next[TF_BIT] = 1'b0;
		end else if (doRet) begin
			flags_next = saved_reg;
		end
		flags_next = (flags_next & FLAG_MASK) | FLAG_RSV;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg <= FLAG_RSV;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			saved_reg <= FLAG_RSV;
		end else if (takeIrq || takeTrace) begin
			saved_reg <= flags_reg;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				gen_reg[i] <= 16'h0000;
			end
		end else begin
			if (wrGen) begin
				gen_reg[wa[4:2]] <= merge16(gen_reg[wa[4:2]], wd[15:0],
					wStrb_reg[1:0]);
			end
			if (wrAlu) begin
				if (byteMode) begin
					gen_reg[IDX_ACC][7:0] <= aluRes[7:0];
				end else begin
					gen_reg[IDX_ACC] <= aluRes;
				end
			end
			if (takeIrq || takeTrace) begin
				gen_reg[IDX_SP] <= gen_reg[IDX_SP] - STACK_STEP;
			end
			if (doRet) begin
				gen_reg[IDX_SP] <= gen_reg[IDX_SP] + STACK_STEP;
			end
			if (strStep) begin
				if (flags_reg[DF_BIT]) begin
					gen_reg[IDX_SI] <= gen_reg[IDX_SI] - strDelta;
					gen_reg[IDX_DI] <= gen_reg[IDX_DI] - strDelta;
				end else begin
					gen_reg[IDX_SI] <= gen_reg[IDX_SI] + strDelta;
					gen_reg[IDX_DI] <= gen_reg[IDX_DI] + strDelta;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				seg_reg[i] <= 16'h0000;
			end
			ip_reg <= 16'h0000;
			opnd_reg <= 16'h0000;
		end else begin
			if (wrSeg) begin
				seg_reg[wa[3:2]] <= merge16(seg_reg[wa[3:2]], wd[15:0],
					wStrb_reg[1:0]);
			end
			if (wrIp) begin
				ip_reg <= merge16(ip_reg, wd[15:0], wStrb_reg[1:0]);
			end
			if (wrOpnd) begin
				opnd_reg <= merge16(opnd_reg, wd[15:0], wStrb_reg[1:0]);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_reg <= 16'h0000;
		end else if (wrAlu) begin
			result_reg <= aluRes;
		end
	end

	always_comb begin
		case (wd[21:20])
			2'b00: agenBase = gen_reg[IDX_BP];
			2'b01: agenBase = gen_reg[IDX_BASE];
			2'b10: agenBase = gen_reg[IDX_DI];
			default: agenBase = gen_reg[IDX_SI];
		endcase
		if (wd[18]) begin
			agenSeg = seg_reg[SEG_STACK];
			agenOfs = gen_reg[IDX_SP];
		end else begin
			agenSeg = seg_reg[wd[17:16]];
			// The sum stays 16 bits so it wraps inside the segment.
			agenOfs = wd[15:0] + (wd[19] ? agenBase : 16'h0000);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			memAddr <= 20'h00000;
		end else if (wrAgen) begin
			memAddr <= physAddr(agenSeg, agenOfs);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ioAddr <= 16'h0000;
			ioAddrReserved <= 1'b0;
		end else if (wrPort) begin
			if (wd[16]) begin
				ioAddr <= gen_reg[IDX_DATA];
				ioAddrReserved <= gen_reg[IDX_DATA] >= RSV_PORT_LO
					&& gen_reg[IDX_DATA] <= RSV_PORT_HI;
			end else begin
				ioAddr <= {8'h00, wd[7:0]};
				ioAddrReserved <= wd[7:0] >= RSV_PORT_LO[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			intAck <= 1'b0;
			traceIrq <= 1'b0;
		end else begin
			intAck <= takeIrq;
			traceIrq <= takeTrace;
		end
	end

	always_comb begin
		rdWord = 32'h0000_0000;
		rdHit = mapped(s_axi_araddr[7:0]);
		if (s_axi_araddr[7:5] == 3'b000) begin
			rdWord = {16'h0000, gen_reg[s_axi_araddr[4:2]]};
		end else if (s_axi_araddr[7:4] == OFS_SEG[7:4]) begin
			rdWord = {16'h0000, seg_reg[s_axi_araddr[3:2]]};
		end else if (s_axi_araddr[7:0] == OFS_IP) begin
			rdWord = {16'h0000, ip_reg};
		end else if (s_axi_araddr[7:0] == OFS_FLAGS) begin
			rdWord = {16'h0000, flags_reg};
		end else if (s_axi_araddr[7:0] == OFS_OPND) begin
			rdWord = {16'h0000, opnd_reg};
		end else if (s_axi_araddr[7:0] == OFS_ALU) begin
			rdWord = {16'h0000, result_reg};
		end else if (s_axi_araddr[7:0] == OFS_AGEN
			|| s_axi_araddr[7:0] == OFS_PHYS) begin
			rdWord = {12'h000, memAddr};
		end else if (s_axi_araddr[7:0] == OFS_PORT) begin
			rdWord = {15'h0000, ioAddrReserved, ioAddr};
		end else if (s_axi_araddr[7:0] == OFS_SAVED) begin
			rdWord = {16'h0000, saved_reg};
		end
		if (!rdHit) begin
			rdWord = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdWord;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	rsv_bits_a: assert property ((flags_reg & ~FLAG_MASK) == FLAG_RSV)
		else $error("reserved flag bits moved");

	seg_shift_a: assert property (wrAgen && !wd[18] && !wd[19] |=>
		memAddr == physAddr($past(agenSeg), $past(wd[15:0])))
		else $error("physical address wrong");

	stack_seg_a: assert property (wrAgen && wd[18] |=>
		memAddr == physAddr($past(seg_reg[SEG_STACK]),
		$past(gen_reg[IDX_SP])))
		else $error("stack access not in stack segment");

	irq_mask_a: assert property (stepEnd && !flags_reg[IF_BIT] |=>
		!intAck)
		else $error("masked interrupt taken");

	trace_clear_a: assert property (traceIrq |->
		!flags_reg[TF_BIT] && saved_reg[TF_BIT])
		else $error("trace flag not cleared after push");

	zero_flag_a: assert property (wrAlu |=>
		flags_reg[ZF_BIT] == (result_reg == 16'h0000))
		else $error("zero flag wrong");

	parity_a: assert property (wrAlu |=>
		flags_reg[PF_BIT] == ~^result_reg[7:0])
		else $error("parity flag wrong");

	dir_step_a: assert property (strStep && flags_reg[DF_BIT] &&
		!wd[3] |=> gen_reg[IDX_SI] == $past(gen_reg[IDX_SI]) - 16'h0001)
		else $error("string index not decremented");

	port_ext_a: assert property (wrPort && !wd[16] |=>
		ioAddr == {8'h00, $past(wd[7:0])})
		else $error("short port number not zero-extended");
endmodule
`default_nettype wire

// ==== xrsa_register_set_tb.sv ====
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module xrsa_register_set_tb import xrsa_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetN, awValid, wValid, bReady, arValid, rReady, irq;
	logic awReady, wReady, bValid, arReady, rValid, intAck, traceIrq;
	logic ioAddrReserved;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData, d;
	logic [3:0] wStrb;
	logic [1:0] bResp, rResp, lastB, lastR;
	logic [19:0] memAddr;
	logic [15:0] ioAddr;
	int errorCnt = 0;
	int testsRun = 0;
	int ackCnt = 0;
	int trcCnt = 0;
	int cycles = 0;
	int a0, t0;

	xrsa_register_set u_dut (.clk(clk), .reset_n(resetN),
		.s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .irqIn(irq), .intAck(intAck),
		.traceIrq(traceIrq), .memAddr(memAddr), .ioAddr(ioAddr),
		.ioAddrReserved(ioAddrReserved));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Pulses last one cycle, so they are counted here rather than polled.
	always @(posedge clk) begin
		cycles++;
		// An unknown pulse counts too, so it cannot slip past a zero check.
		if (intAck !== 1'b0) ackCnt++;
		if (traceIrq !== 1'b0) trcCnt++;
		if (cycles == 20000) begin
			errorCnt++;
			stopTest();
		end
	end

	task automatic stopTest();
		if (errorCnt == 0 && testsRun > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic wrs(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		awAddr <= a;
		wData <= v;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
		end while (bValid !== 1'b1 && n < 50);
		lastB = bResp;
		bReady <= 1'b0;
		if (n >= 50) errorCnt++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		wrs(a, v, 4'hF);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arValid && arReady) arValid <= 1'b0;
		end while (rValid !== 1'b1 && n < 50);
		d = rData;
		lastR = rResp;
		rReady <= 1'b0;
		if (n >= 50) errorCnt++;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a);
		`CHK($sformatf("reg %0h", a), e, d & m)
		`CHK("rresp", RESP_OKAY, lastR)
	endtask

	task automatic tReset();
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F002);
		rd(8'h20);
		`CHK("rresp", RESP_SLVERR, lastR)
		wr(8'h20, 32'h0000FFFF);
		`CHK("bresp", RESP_SLVERR, lastB)
	endtask

	task automatic tRegs();
		wr(OFS_GEN, 32'h00001234);
		`CHK("bresp", RESP_OKAY, lastB)
		// Only the low byte lane is enabled, so the high half must hold.
		wrs(OFS_GEN, 32'h0000AB56, 4'h1);
		rdc(OFS_GEN, 32'h0000FFFF, 32'h00001256);
		wrs(OFS_GEN, 32'h0000AB00, 4'h2);
		rdc(OFS_GEN, 32'h0000FFFF, 32'h0000AB56);
		wr(OFS_SEG + 8'h04, 32'h00004321);
		rdc(OFS_SEG + 8'h04, 32'h0000FFFF, 32'h00004321);
		wr(OFS_IP, 32'h0000BEEF);
		rdc(OFS_IP, 32'h0000FFFF, 32'h0000BEEF);
		wr(OFS_FLAGS, 32'h0000FFFF);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000FFD7);
	endtask

	task automatic alu(input logic [31:0] acc, input logic [31:0] b,
		input logic [31:0] op);
		wr(OFS_GEN, acc);
		wr(OFS_OPND, b);
		wr(OFS_ALU, op);
	endtask

	task automatic tAlu();
		wr(OFS_FLAGS, 32'h00000000);
		alu(32'h00007FFF, 32'h00000001, 32'h00000000);
		rdc(OFS_GEN, 32'h0000FFFF, 32'h00008000);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F896);
		alu(32'h00000000, 32'h00000001, 32'h00000001);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F097);
		// A logic result of zero keeps the half carry from the subtract.
		wr(OFS_OPND, 32'h00000000);
		wr(OFS_ALU, 32'h00000002);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F056);
		alu(32'h000012FF, 32'h00000001, 32'h00000004);
		rdc(OFS_GEN, 32'h0000FFFF, 32'h00001200);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F057);
		wr(OFS_ALU, 32'h00000003);
		rdc(OFS_ALU, 32'h0000FFFF, 32'h00001201);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F012);
	endtask

	task automatic ag(input logic [31:0] cmd, input logic [19:0] e);
		wr(OFS_AGEN, cmd);
		rdc(OFS_PHYS, 32'h000FFFFF, {12'h000, e});
		`CHK("memAddr", e, memAddr)
	endtask

	task automatic tAgen();
		wr(OFS_SEG + 8'h0C, 32'h000012A4);
		ag(32'h00030022, 20'h12A62);
		wr(OFS_SEG, 32'h0000FFFF);
		ag(32'h00000020, 20'h00010);
		wr(OFS_SEG + 8'h08, 32'h00001000);
		wr(OFS_GEN + 8'h10, 32'h00000100);
		ag(32'h00070022, 20'h10100);
		wr(OFS_GEN + 8'h14, 32'h00000010);
		ag(32'h000B0002, 20'h12A52);
		wr(OFS_GEN + 8'h0C, 32'h00000100);
		ag(32'h001B0002, 20'h12B42);
	endtask

	task automatic tPort();
		wr(OFS_PORT, 32'h000001FF);
		rdc(OFS_PORT, 32'h0001FFFF, 32'h000100FF);
		wr(OFS_PORT, 32'h000000F7);
		`CHK("ioAddrReserved", 1'b0, ioAddrReserved)
		wr(OFS_GEN + 8'h08, 32'h0000ABCD);
		wr(OFS_PORT, 32'h00010000);
		`CHK("ioAddr", 16'hABCD, ioAddr)
		wr(OFS_GEN + 8'h08, 32'h000000FA);
		wr(OFS_PORT, 32'h00010000);
		`CHK("ioAddrReserved", 1'b1, ioAddrReserved)
	endtask

	task automatic step(input logic [31:0] fl, input logic [31:0] cmd);
		wr(OFS_FLAGS, fl);
		a0 = ackCnt;
		t0 = trcCnt;
		wr(OFS_STEP, cmd);
		repeat (3) @(posedge clk);
	endtask

	task automatic tStep();
		irq <= 1'b1;
		step(32'h00000201, 32'h00000001);
		`CHK("intAck", 1, ackCnt - a0)
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F003);
		rdc(OFS_SAVED, 32'h0000FFFF, 32'h0000F203);
		rdc(OFS_GEN + 8'h10, 32'h0000FFFF, 32'h000000FE);
		wr(OFS_STEP, 32'h00000002);
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F203);
		rdc(OFS_GEN + 8'h10, 32'h0000FFFF, 32'h00000100);
		step(32'h00000000, 32'h00000001);
		`CHK("intAck", 0, ackCnt - a0)
		irq <= 1'b0;
		step(32'h00000500, 32'h00000001);
		`CHK("traceIrq", 1, trcCnt - t0)
		rdc(OFS_FLAGS, 32'h0000FFFF, 32'h0000F402);
		wr(OFS_GEN + 8'h18, 32'h00000010);
		wr(OFS_GEN + 8'h1C, 32'h00000020);
		step(32'h00000400, 32'h0000000C);
		rdc(OFS_GEN + 8'h18, 32'h0000FFFF, 32'h0000000E);
		rdc(OFS_GEN + 8'h1C, 32'h0000FFFF, 32'h0000001E);
		step(32'h00000000, 32'h00000004);
		rdc(OFS_GEN + 8'h18, 32'h0000FFFF, 32'h0000000F);
		step(32'h00000400, 32'h00000004);
		rdc(OFS_GEN + 8'h18, 32'h0000FFFF, 32'h0000000E);
	endtask

	initial begin
		resetN = 1'b0;
		{awValid, wValid, bReady, arValid, rReady, irq} = 6'h00;
		awAddr = 8'h00;
		arAddr = 8'h00;
		wData = 32'h00000000;
		wStrb = 4'hF;
		repeat (8) @(posedge clk);
		resetN <= 1'b1;
		tReset();
		tRegs();
		tAlu();
		tAgen();
		tPort();
		tStep();
		stopTest();
	end
endmodule
`undef CHK
`default_nettype wire
